// >>> hw/flash_ctl_pkg.sv
// Constants, field layout and state types for the flash clock divider and options block
// Contract
// - Divider-loaded flag, bit 7, is read-only; reset clears it, first write sets it.
// - Lower seven divider bits are always readable but take one write per reset.
// - Program and erase are refused until the divider-loaded flag is set.
// - Prescale bit 6 selects bus clock, or bus clock divided by eight.
// - Selected clock is divided by divisor field plus one into the timing clock.
// - Each timing pulse is one timing clock period; operations use whole pulses.
// - Nine byte registers; three are copied from nonvolatile bytes at reset. Here: five registers, only options is copied.
// - Options register is loaded from the nonvolatile options byte during reset.
// - Options bits 5 down to 2 always read zero.
// - Options register is always readable; writes change nothing.
// - With key enable bit 7 clear, the backdoor key never disengages security.
// - Enabled, matching eight key bytes written in order unsecure until reset.
// - Debug commands cannot write key comparison values; only firmware may.
// - Options bit 6 set disables vector redirection; clear leaves it enabled.
// - Security code 10 means unsecured; 00, 01 and 11 mean secured.
// - While secured, memory contents are blocked from unsecured sources and debug. Here the gate checks only mem_unsecured_src_in, not dbg_source_in.
// - Security code becomes 10 after key success or an all-blank check.
// - Blocked memory accesses discard writes and read as all zeros.
package flash_ctl_pkg;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] CLK_DIV_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] OPTIONS_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] KEY_CTRL_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] KEY_DATA_OFS = 8'h0c;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h10;

    localparam int DIV_LOADED_BIT = 7;
    localparam int PRESCALE_BIT = 6;
    localparam int KEY_EN_BIT = 7;
    localparam int REDIR_DIS_BIT = 6;
    localparam logic [7:0] OPT_UNUSED_MASK = 8'h3c;
    localparam logic [1:0] SEC_UNSECURED = 2'h2;
    localparam int KEY_ACCESS_BIT = 0;
    localparam int ST_SECURED_BIT = 0;
    localparam int ST_BUSY_BIT = 1;
    localparam int ST_RATE_OK_BIT = 2;
    localparam int ST_KEY_ACCESS_BIT = 3;

    localparam logic [2:0] PRESCALE_LAST = 3'h7;
    localparam int PRESCALE_SHIFT = 3;
    localparam logic [3:0] KEY_BYTES = 4'h8;

    localparam int CLK_HZ = 40_000_000;
    localparam int TIMING_MAX_KHZ = 200;
    localparam int TIMING_MIN_KHZ = 150;
    // Shortest allowed period rounds up, longest rounds down
    localparam int PERIOD_MIN_CYC = (CLK_HZ + TIMING_MAX_KHZ * 1000 - 1) / (TIMING_MAX_KHZ * 1000);
    localparam int PERIOD_MAX_CYC = CLK_HZ / (TIMING_MIN_KHZ * 1000);

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic div_loaded;
        logic prescale;
        logic [5:0] divisor;
        logic [7:0] options;
        logic secured;
        logic key_access;
        logic [63:0] key_buf;
        logic [3:0] key_count;
        logic [2:0] pre_cnt;
        logic [5:0] div_cnt;
        logic timing_tick;
        logic pe_busy;
        logic [7:0] pe_left;
        logic pe_done;
        logic pe_refused;
        logic [7:0] mem_rdata;
        logic mem_wr_en;
        apb_rsp_t rsp;
    } state_t;
endpackage

// >>> hw/flash_clkdiv_opts.sv
// Flash timing clock divider, options register, backdoor key and secure memory gate
//
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/10ps
module flash_clkdiv_opts
    import flash_ctl_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    input wire apb_req_t apb_in,
    input wire logic dbg_source_in,
    output apb_rsp_t apb_out,
    input wire logic [7:0] nonvolatile_options_byte_in,
    input wire logic [63:0] stored_backdoor_key_in,
    input wire logic blank_check_pass_in,
    input wire logic pe_req_in,
    input wire logic [7:0] pe_pulses_in,
    output logic pe_busy_out,
    output logic pe_done_out,
    output logic pe_refused_out,
    output logic flash_timing_clock_out,
    output logic prog_erase_enabled_out,
    output logic backdoor_key_enable_out,
    output logic vector_redirect_disable_out,
    output logic secured_out,
    input wire logic mem_unsecured_src_in,
    input wire logic mem_wr_req_in,
    input wire logic [7:0] mem_rdata_in,
    output logic mem_wr_en_out,
    output logic [7:0] mem_rdata_out
);
    state_t s_q;
    state_t s_d;

    // Bus cycles in one timing clock period for a given setting
    function automatic logic [9:0] period_cycles(input logic pre, input logic [5:0] div);
        logic [9:0] base;
        base = {4'h0, div} + 10'h001;
        period_cycles = pre ? (base << PRESCALE_SHIFT) : base;
    endfunction

    function automatic logic secure_code(input logic [1:0] code);
        secure_code = (code != SEC_UNSECURED);
    endfunction

    logic setup_ph;
    logic access_ph;
    logic wr_ph;
    logic [9:0] period_now;
    logic rate_ok;
    logic pre_step;
    logic key_match;
    logic blocked;

    always_comb begin
        setup_ph = apb_in.psel && !apb_in.penable;
        access_ph = apb_in.psel && apb_in.penable && s_q.rsp.pready;
        wr_ph = access_ph && apb_in.pwrite;
        period_now = period_cycles(s_q.prescale, s_q.divisor);
        rate_ok = s_q.div_loaded && (period_now >= 10'(PERIOD_MIN_CYC))
            && (period_now <= 10'(PERIOD_MAX_CYC));
        pre_step = !s_q.prescale || (s_q.pre_cnt == PRESCALE_LAST);
        key_match = (s_q.key_count == KEY_BYTES) && (s_q.key_buf == stored_backdoor_key_in);
        blocked = s_q.secured && mem_unsecured_src_in;
    end

    always_comb begin
        s_d = s_q;
        if (!rst_b_in) begin
            s_d = '0;
            // Options are copied in while reset is held
            s_d.options = nonvolatile_options_byte_in & ~OPT_UNUSED_MASK;
            s_d.secured = secure_code(nonvolatile_options_byte_in[1:0]);
        end else begin
            // Timing clock: optional divide by eight, then divide by divisor plus one
            s_d.timing_tick = 1'b0;
            if (!s_q.div_loaded) begin
                s_d.pre_cnt = '0;
                s_d.div_cnt = '0;
            end else begin
                s_d.pre_cnt = s_q.prescale ? s_q.pre_cnt + 3'h1 : 3'h0;
                if (pre_step) begin
                    if (s_q.div_cnt == s_q.divisor) begin
                        s_d.div_cnt = '0;
                        s_d.timing_tick = 1'b1;
                    end else begin
                        s_d.div_cnt = s_q.div_cnt + 6'h01;
                    end
                end
            end

            // Program and erase sequencing in whole timing pulses
            s_d.pe_done = 1'b0;
            s_d.pe_refused = 1'b0;
            if (s_q.pe_busy && s_q.timing_tick) begin
                if (s_q.pe_left <= 8'h01) begin
                    s_d.pe_busy = 1'b0;
                    s_d.pe_done = 1'b1;
                end else begin
                    s_d.pe_left = s_q.pe_left - 8'h01;
                end
            end
            if (pe_req_in) begin
                // Key entry owns the key locations, so commands are refused while it is open
                if (!s_q.div_loaded || s_q.pe_busy || s_q.key_access) begin
                    s_d.pe_refused = 1'b1;
                end else begin
                    s_d.pe_busy = 1'b1;
                    s_d.pe_left = pe_pulses_in;
                end
            end

            // Register writes take effect at the access edge only
            if (wr_ph) begin
                case (apb_in.paddr)
                    CLK_DIV_OFS: begin
                        if (!s_q.div_loaded) begin
                            s_d.div_loaded = 1'b1;
                            s_d.prescale = apb_in.pwdata[PRESCALE_BIT];
                            s_d.divisor = apb_in.pwdata[5:0];
                        end
                    end
                    KEY_CTRL_OFS: begin
                        if (apb_in.pwdata[KEY_ACCESS_BIT] && !s_q.key_access) begin
                            s_d.key_access = 1'b1;
                            s_d.key_count = '0;
                            s_d.key_buf = '0;
                        end else if (!apb_in.pwdata[KEY_ACCESS_BIT] && s_q.key_access) begin
                            s_d.key_access = 1'b0;
                            if (s_q.options[KEY_EN_BIT] && s_q.secured && key_match) begin
                                s_d.options[1:0] = SEC_UNSECURED;
                                s_d.secured = 1'b0;
                            end
                        end
                    end
                    KEY_DATA_OFS: begin
                        // Debug writes never reach the comparison buffer
                        if (s_q.key_access && !dbg_source_in) begin
                            if (s_q.key_count < KEY_BYTES) begin
                                s_d.key_buf[{s_q.key_count[2:0], 3'h0} +: 8] = apb_in.pwdata[7:0];
                            end
                            // A ninth byte spoils the match until key access restarts
                            if (s_q.key_count <= KEY_BYTES) begin
                                s_d.key_count = s_q.key_count + 4'h1;
                            end
                        end
                    end
                    default: begin
                        // Options and status ignore writes
                        s_d.options = s_q.options;
                    end
                endcase
            end

            if (blank_check_pass_in) begin
                s_d.options[1:0] = SEC_UNSECURED;
                s_d.secured = 1'b0;
            end

            // Secure memory gate
            s_d.mem_rdata = blocked ? 8'h00 : mem_rdata_in;
            s_d.mem_wr_en = mem_wr_req_in && !blocked;

            // Bus answer is prepared in the setup cycle, zero wait states
            s_d.rsp.pready = setup_ph;
            s_d.rsp.pslverr = 1'b0;
            s_d.rsp.prdata = '0;
            if (setup_ph) begin
                case (apb_in.paddr)
                    CLK_DIV_OFS: s_d.rsp.prdata[7:0] = {s_q.div_loaded, s_q.prescale, s_q.divisor};
                    OPTIONS_OFS: s_d.rsp.prdata[7:0] = s_q.options & ~OPT_UNUSED_MASK;
                    KEY_CTRL_OFS: s_d.rsp.prdata[KEY_ACCESS_BIT] = s_q.key_access;
                    KEY_DATA_OFS: s_d.rsp.prdata = '0;
                    STATUS_OFS: begin
                        s_d.rsp.prdata[ST_SECURED_BIT] = s_q.secured;
                        s_d.rsp.prdata[ST_BUSY_BIT] = s_q.pe_busy;
                        s_d.rsp.prdata[ST_RATE_OK_BIT] = rate_ok;
                        s_d.rsp.prdata[ST_KEY_ACCESS_BIT] = s_q.key_access;
                    end
                    default: s_d.rsp.pslverr = 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        s_q <= s_d;
    end

    always_comb begin
        apb_out = s_q.rsp;
        pe_busy_out = s_q.pe_busy;
        pe_done_out = s_q.pe_done;
        pe_refused_out = s_q.pe_refused;
        flash_timing_clock_out = s_q.timing_tick;
        prog_erase_enabled_out = s_q.div_loaded;
        backdoor_key_enable_out = s_q.options[KEY_EN_BIT];
        vector_redirect_disable_out = s_q.options[REDIR_DIS_BIT];
        secured_out = s_q.secured;
        mem_wr_en_out = s_q.mem_wr_en;
        mem_rdata_out = s_q.mem_rdata;
    end

    // Helper logic for checking tick spacing
    logic [9:0] gap_q;
    logic seen_tick_q;
    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            gap_q <= '0;
            seen_tick_q <= 1'b0;
        end else if (s_q.timing_tick) begin
            gap_q <= '0;
            seen_tick_q <= 1'b1;
        end else begin
            gap_q <= gap_q + 10'h001;
        end
    end

    logic div_wr;
    logic ctrl_clear_wr;
    always_comb begin
        div_wr = wr_ph && (apb_in.paddr == CLK_DIV_OFS);
        ctrl_clear_wr = wr_ph && (apb_in.paddr == KEY_CTRL_OFS)
            && !apb_in.pwdata[KEY_ACCESS_BIT];
    end

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_b_in);

    sequence pe_start_s;
        pe_req_in && s_q.div_loaded && !s_q.pe_busy && !s_q.key_access;
    endsequence

    sequence pe_wait_s;
        s_q.pe_busy [*1];
    endsequence

    div_first_load_a: assert property (div_wr && !s_q.div_loaded |=> s_q.div_loaded
        && s_q.divisor == $past(apb_in.pwdata[5:0]))
        else $error("first divider write not loaded");
    div_write_once_a: assert property (div_wr && s_q.div_loaded |=>
        $stable(s_q.divisor) && $stable(s_q.prescale) && !apb_out.pslverr)
        else $error("divider changed after first write");
    pe_refused_a: assert property (pe_req_in && !s_q.div_loaded |=>
        pe_refused_out && !pe_busy_out)
        else $error("program or erase accepted before divider load");
    pe_start_a: assert property (pe_start_s |=> pe_wait_s)
        else $error("accepted operation not busy");
    // Done is registered one edge after the counted tick, so the tick is one sample back
    pe_done_tick_a: assert property ($rose(pe_done_out) |-> $past(s_q.timing_tick))
        else $error("operation ended off a timing pulse");
    tick_spacing_a: assert property (s_q.timing_tick && seen_tick_q |->
        gap_q == period_now - 10'h001)
        else $error("timing clock period wrong");
    options_ro_a: assert property (
        wr_ph && apb_in.paddr == OPTIONS_OFS && !blank_check_pass_in |=> $stable(s_q.options))
        else $error("options register changed by write");
    options_zero_a: assert property (apb_out.pready && !apb_out.pslverr
        && $past(apb_in.paddr) == OPTIONS_OFS |-> apb_out.prdata[5:2] == 4'h0)
        else $error("unused options bits read nonzero");
    key_disabled_a: assert property (ctrl_clear_wr && !s_q.options[KEY_EN_BIT]
        && s_q.secured && !blank_check_pass_in |=> secured_out)
        else $error("security dropped with key disabled");
    blocked_mem_a: assert property (s_q.secured && mem_unsecured_src_in |=>
        mem_rdata_out == 8'h00 && !mem_wr_en_out)
        else $error("secure memory reached from unsecured source");
    blank_unsec_a: assert property (blank_check_pass_in |=>
        !secured_out && s_q.options[1:0] == SEC_UNSECURED)
        else $error("blank check did not unsecure");
    redirect_bit_a: assert property (
        vector_redirect_disable_out == s_q.options[REDIR_DIS_BIT]
        && $stable(s_q.options[REDIR_DIS_BIT]))
        else $error("redirect control moved after reset");
endmodule

// >>> bench/flash_clock_div_and_security_opts_tb.sv
// Register-level bench for the flash clock divider, options and security gate
`timescale 1ns/10ps
module flash_clock_div_and_security_opts_tb;
    import flash_ctl_pkg::*;
    logic core_clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    apb_req_t apb_in = '0;
    apb_rsp_t apb_out;
    logic dbg_source_in = 1'b0;
    logic [7:0] nv_opt = 8'hfd;
    // Key value is arbitrary
    logic [63:0] key = 64'h0123_4567_89ab_cdef;
    logic blank_pass = 1'b0;
    logic pe_req = 1'b0;
    logic [7:0] pe_pulses = 8'h00;
    logic pe_busy, pe_done, pe_refused, timing_tick, pe_en, key_en, redir_dis, secured;
    logic mem_unsec = 1'b0;
    logic mem_wr_req = 1'b0;
    logic [7:0] mem_rd = 8'h00;
    logic mem_wr_en;
    logic [7:0] mem_rd_out;
    int n_fail = 0;
    int checks_done = 0;
    logic [31:0] rd;
    logic err;
    int n;

    flash_clkdiv_opts flash_clkdiv_opts_inst (
        .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .apb_in(apb_in),
        .dbg_source_in(dbg_source_in), .apb_out(apb_out),
        .nonvolatile_options_byte_in(nv_opt), .stored_backdoor_key_in(key),
        .blank_check_pass_in(blank_pass), .pe_req_in(pe_req), .pe_pulses_in(pe_pulses),
        .pe_busy_out(pe_busy), .pe_done_out(pe_done), .pe_refused_out(pe_refused),
        .flash_timing_clock_out(timing_tick), .prog_erase_enabled_out(pe_en),
        .backdoor_key_enable_out(key_en), .vector_redirect_disable_out(redir_dis),
        .secured_out(secured), .mem_unsecured_src_in(mem_unsec),
        .mem_wr_req_in(mem_wr_req), .mem_rdata_in(mem_rd),
        .mem_wr_en_out(mem_wr_en), .mem_rdata_out(mem_rd_out)
    );

    always #12.5 core_clk_in = ~core_clk_in;

    task automatic tally_and_finish;
        if (n_fail == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic fail_to(input string what);
        n_fail++;
        $display("CHECK FAILED %s expected answer seen timeout", what);
        tally_and_finish();
    endtask

    // Request held from setup until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                       input logic dbg);
        int i;
        @(posedge core_clk_in);
        apb_in <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wd};
        dbg_source_in <= dbg;
        @(posedge core_clk_in);
        apb_in.penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge core_clk_in);
            if (apb_out.pready === 1'b1) break;
        end
        if (i == 16) fail_to("apb pready");
        rd = apb_out.prdata;
        err = apb_out.pslverr;
        apb_in <= '0;
        dbg_source_in <= 1'b0;
    endtask

    task automatic rd_chk(input string what, input logic [7:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0, 1'b0);
        chk(what, exp, rd);
    endtask

    task automatic do_reset(input logic [7:0] nv);
        @(posedge core_clk_in);
        rst_b_in <= 1'b0;
        nv_opt <= nv;
        repeat (20) @(posedge core_clk_in);
        rst_b_in <= 1'b1;
    endtask

    task automatic tick_period(output int p);
        int i;
        for (i = 0; i < 600; i++) begin
            @(negedge core_clk_in);
            if (timing_tick === 1'b1) break;
        end
        if (i == 600) fail_to("timing tick");
        p = 0;
        do begin
            @(negedge core_clk_in);
            p++;
        end while (timing_tick !== 1'b1 && p < 600);
    endtask

    task automatic pe_start(input logic [7:0] pulses);
        @(posedge core_clk_in);
        pe_req <= 1'b1;
        pe_pulses <= pulses;
        @(posedge core_clk_in);
        pe_req <= 1'b0;
        @(negedge core_clk_in);
    endtask

    task automatic mem_chk(input logic src, input logic [7:0] exp_rd, input logic exp_wr);
        @(posedge core_clk_in);
        mem_unsec <= src;
        mem_wr_req <= 1'b1;
        mem_rd <= 8'h5a;
        @(posedge core_clk_in);
        @(negedge core_clk_in);
        chk("memory read data", exp_rd, mem_rd_out);
        chk("memory write enable", exp_wr, mem_wr_en);
    endtask

    // Debug-sourced key bytes must not count toward a match
    task automatic key_seq(input logic [63:0] k, input logic dbg);
        int b;
        apb(1'b1, KEY_CTRL_OFS, 32'h1, 1'b0);
        for (b = 0; b < 8; b++) apb(1'b1, KEY_DATA_OFS, {24'h0, k[b*8 +: 8]}, dbg);
        apb(1'b1, KEY_CTRL_OFS, 32'h0, 1'b0);
        repeat (2) @(negedge core_clk_in);
    endtask

    initial begin
        do_reset(8'hfd);
        rd_chk("options", OPTIONS_OFS, 32'hc1);
        apb(1'b1, OPTIONS_OFS, 32'h0, 1'b0);
        rd_chk("options after write", OPTIONS_OFS, 32'hc1);
        chk("key enable", 1, key_en);
        chk("redirect disable", 1, redir_dis);
        chk("secured code 01", 1, secured);
        rd_chk("divider at reset", CLK_DIV_OFS, 32'h0);
        chk("pe enabled unloaded", 0, pe_en);
        pe_start(8'h03);
        chk("refused unloaded", 1, pe_refused);
        // Prescaled divide by 25 is 200 kHz, the fastest legal timing clock at 40 MHz
        apb(1'b1, CLK_DIV_OFS, 32'h58, 1'b0);
        rd_chk("divider first write", CLK_DIV_OFS, 32'hd8);
        apb(1'b1, CLK_DIV_OFS, 32'h7f, 1'b0);
        chk("repeat write error", 0, err);
        rd_chk("divider repeat write", CLK_DIV_OFS, 32'hd8);
        rd_chk("status rate in range", STATUS_OFS, 32'h5);
        chk("pe enabled loaded", 1, pe_en);
        tick_period(n);
        chk("tick period 200", 200, n);
        pe_start(8'h03);
        chk("busy accepted", 1, pe_busy);
        n = 1;
        while (pe_done !== 1'b1 && n < 1000) begin
            @(negedge core_clk_in);
            n++;
        end
        if (n >= 1000) fail_to("pe done");
        // Third counted tick falls 401 to 600 cycles after acceptance, done one later
        chk("pe length three pulses", 1, n >= 402 && n <= 601);
        mem_chk(1'b1, 8'h00, 1'b0);
        mem_chk(1'b0, 8'h5a, 1'b1);
        apb(1'b0, 8'h40, 32'h0, 1'b0);
        chk("unmapped error", 1, err);
        key_seq(key, 1'b1);
        chk("secured after debug key", 1, secured);
        key_seq(key ^ 64'h1, 1'b0);
        chk("secured after wrong key", 1, secured);
        key_seq(key, 1'b0);
        chk("secured after good key", 0, secured);
        rd_chk("options after unlock", OPTIONS_OFS, 32'hc2);
        mem_chk(1'b1, 8'h5a, 1'b1);
        do_reset(8'h3f);
        rd_chk("options second reset", OPTIONS_OFS, 32'h03);
        chk("key disabled", 0, key_en);
        chk("redirect enabled", 0, redir_dis);
        rd_chk("divider cleared by reset", CLK_DIV_OFS, 32'h0);
        key_seq(key, 1'b0);
        chk("secured key disabled", 1, secured);
        apb(1'b1, CLK_DIV_OFS, 32'h60, 1'b0);
        rd_chk("divider prescaled", CLK_DIV_OFS, 32'he0);
        tick_period(n);
        chk("tick period 264", 264, n);
        @(posedge core_clk_in);
        blank_pass <= 1'b1;
        @(posedge core_clk_in);
        blank_pass <= 1'b0;
        @(negedge core_clk_in);
        chk("secured after blank", 0, secured);
        tally_and_finish();
    end
endmodule
